//--- dtcc_pkg.sv
// Shared constants and types for the transfer completion code reporter
`default_nettype none
package dtcc_pkg;
  // Interrupt codes
  localparam logic [7:0] CODE_SCSI_RST  = 8'h01;
  localparam logic [7:0] CODE_PE_DMA    = 8'h21;
  localparam logic [7:0] CODE_PE_MPU    = 8'h22;
  localparam logic [7:0] CODE_PE_SCSI   = 8'h24;
  localparam logic [7:0] CODE_PE_DMA_SC = 8'h25;
  localparam logic [7:0] CODE_PE_MPU_SC = 8'h26;
  localparam logic [7:0] CODE_OFS_ERR   = 8'h29;
  localparam logic [7:0] CODE_REQ_SHORT = 8'h2A;
  localparam logic [7:0] CODE_OFS_SHORT = 8'h2B;
  localparam logic [7:0] CODE_TIMEOUT   = 8'h2C;
  localparam logic [7:0] CODE_BUS_FREE  = 8'h31;
  localparam logic [7:0] CODE_PHASE_CHG = 8'h32;
  localparam logic [7:0] CODE_BAD_PHASE = 8'h54;
  localparam logic [7:0] CODE_MSG_RX    = 8'h55;
  localparam logic [7:0] CODE_STAT_RX   = 8'h56;
  localparam logic [7:0] CODE_MSG_FULL  = 8'h5D;
  localparam logic [7:0] CODE_STAT_FULL = 8'h5E;
  localparam logic [7:0] CODE_NORMAL    = 8'h60;
  localparam logic [7:0] CODE_ZERO_CNT  = 8'h65;
  localparam logic [7:0] CODE_PAUSE     = 8'h67;
  localparam logic [7:0] CODE_FREE_PRE  = 8'h70;
  // Step codes
  localparam logic [7:0] STEP_BEFORE    = 8'h00;
  localparam logic [7:0] STEP_DURING    = 8'h01;
  localparam logic [7:0] STEP_MANUAL    = 8'h02;
  localparam logic [7:0] STEP_LAST_ACK  = 8'h09;
  localparam logic [7:0] STEP_AUTO_ACK  = 8'h0A;
  // SCSI bus phase encodings (MSG, C/D, I/O)
  localparam logic [2:0] PH_DATA_OUT    = 3'h0;
  localparam logic [2:0] PH_STATUS      = 3'h3;
  localparam logic [2:0] PH_MSG_IN      = 3'h7;
  // Synchroniser width: SCSI reset and bus free pins
  localparam int unsigned SYNC_W        = 2;
  localparam int unsigned SYNC_RST_BIT  = 0;
  localparam int unsigned SYNC_FREE_BIT = 1;
  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_WAIT   = 6'h02,
    ST_XFER   = 6'h04,
    ST_MSG_RX = 6'h08,
    ST_EXIT   = 6'h10,
    ST_REPORT = 6'h20
  } dtcc_state_type;
  // Whole state of the reporter
  typedef struct packed {
    dtcc_state_type st;
    logic [7:0]     code;
    logic [7:0]     step;
    logic           valid;
    logic           pend22;
    logic           pad;
    logic           atn;
    logic           pe_dma;
    logic           pe_mpu;
    logic           pe_scsi;
    logic           ofs_err;
    logic           req_short;
    logic           rx_status;
  } dtcc_regs_type;
endpackage : dtcc_pkg
`default_nettype wire

//--- dtcc_report.sv
// Completion code reporter for send data transfer commands
`default_nettype none
module dtcc_report (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  // SCSI bus condition pins (asynchronous)
  input  wire logic       scsi_rst_pin_in,
  input  wire logic       bus_free_pin_in,
  // Command and mode controls from the sequencer
  input  wire logic       cmd_start_in,
  input  wire logic       count_zero_in,
  input  wire logic       auto_rx_mode_in,
  input  wire logic       auto_ack_mode_in,
  input  wire logic       sync_mode_in,
  // Transfer engine events
  input  wire logic       first_req_in,
  input  wire logic [2:0] phase_in,
  input  wire logic       rx_buf_full_in,
  input  wire logic       rx_byte_done_in,
  input  wire logic       phase_chg_in,
  input  wire logic       req_timeout_in,
  input  wire logic       pause_in,
  input  wire logic       xfer_done_in,
  input  wire logic       last_ack_rel_in,
  input  wire logic       exit_done_in,
  // Error detectors
  input  wire logic       dma_par_err_in,
  input  wire logic       mpu_par_err_in,
  input  wire logic       scsi_par_err_in,
  input  wire logic       reg_par_err_in,
  input  wire logic       offset_err_in,
  input  wire logic       req_short_in,
  // Host side
  input  wire logic       int_read_in,
  output logic      [7:0] int_code_out,
  output logic      [7:0] int_step_out,
  output logic            int_valid_out,
  // Bus and engine controls
  output logic            atn_out,
  output logic            padding_out,
  output logic            rx_accept_out,
  output logic            exit_req_out,
  output logic            busy_out
);
  import dtcc_pkg::*;

  dtcc_regs_type          r_r;
  dtcc_regs_type          r_nxt;
  logic [SYNC_W-1:0]      pins_s;
  logic                   scsi_rst_s;
  logic                   bus_free_s;
  logic [4:0]             errs;
  logic                   any_err;
  logic [7:0]             err_code;
  logic [7:0]             end_step;

  // Pin conditions cross into the core clock
  dtcc_sync u_sync (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .async_in    ({bus_free_pin_in, scsi_rst_pin_in}),
    .sync_out    (pins_s)
  );

  assign scsi_rst_s = pins_s[SYNC_RST_BIT];
  assign bus_free_s = pins_s[SYNC_FREE_BIT];

  // Combine latched errors into one code, paired faults first
  always_comb begin
    // Bits: DMA, MPU, SCSI, offset, short REQ; a last-cycle error counts
    errs     = {r_r.pe_dma | dma_par_err_in, r_r.pe_mpu | mpu_par_err_in,
                r_r.pe_scsi | scsi_par_err_in,
                r_r.ofs_err | (offset_err_in & sync_mode_in),
                r_r.req_short | req_short_in};
    any_err  = |errs;
    err_code = CODE_NORMAL;
    if (errs[4] && errs[2]) begin
      err_code = CODE_PE_DMA_SC;
    end else if (errs[3] && errs[2]) begin
      err_code = CODE_PE_MPU_SC;
    end else if (errs[1] && errs[0]) begin
      err_code = CODE_OFS_SHORT;
    end else if (errs[4]) begin
      err_code = CODE_PE_DMA;
    end else if (errs[3]) begin
      err_code = CODE_PE_MPU;
    end else if (errs[2]) begin
      err_code = CODE_PE_SCSI;
    end else if (errs[1]) begin
      err_code = CODE_OFS_ERR;
    end else if (errs[0]) begin
      err_code = CODE_REQ_SHORT;
    end
  end

  // Step for an ending transfer; padding never counts as auto ACK
  always_comb begin
    end_step = STEP_DURING;
    if (auto_ack_mode_in && last_ack_rel_in && !r_r.pad) begin
      end_step = any_err ? STEP_LAST_ACK : STEP_AUTO_ACK;
    end else if (!any_err) begin
      end_step = STEP_MANUAL;
    end
  end

  // Next state of the reporter
  always_comb begin
    r_nxt = r_r;
    // Register access parity is queued; a new event beats the clear
    r_nxt.pend22 = r_r.pend22 | reg_par_err_in;
    case (r_r.st)
      ST_IDLE: begin
        if (r_r.pend22) begin
          r_nxt.code   = CODE_PE_MPU;
          r_nxt.step   = STEP_BEFORE;
          r_nxt.valid  = 1'b1;
          r_nxt.pend22 = reg_par_err_in;
          r_nxt.st     = ST_REPORT;
        end else if (cmd_start_in) begin
          r_nxt.pad       = count_zero_in;
          r_nxt.atn       = 1'b0;
          r_nxt.pe_dma    = 1'b0;
          r_nxt.pe_mpu    = 1'b0;
          r_nxt.pe_scsi   = 1'b0;
          r_nxt.ofs_err   = 1'b0;
          r_nxt.req_short = 1'b0;
          r_nxt.st        = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (scsi_rst_s) begin
          r_nxt.code  = CODE_SCSI_RST;
          r_nxt.step  = STEP_BEFORE;
          r_nxt.valid = 1'b1;
          r_nxt.st    = ST_REPORT;
        end else if (bus_free_s && auto_rx_mode_in) begin
          r_nxt.code  = CODE_FREE_PRE;
          r_nxt.step  = STEP_BEFORE;
          r_nxt.valid = 1'b1;
          r_nxt.st    = ST_REPORT;
        end else if (first_req_in) begin
          r_nxt.step = STEP_DURING;
          if (phase_in == PH_DATA_OUT) begin
            r_nxt.st = ST_XFER;
          end else if (auto_rx_mode_in &&
                       (phase_in == PH_MSG_IN ||
                        phase_in == PH_STATUS)) begin
            r_nxt.rx_status = (phase_in == PH_STATUS);
            if (rx_buf_full_in) begin
              r_nxt.code  = (phase_in == PH_STATUS) ?
                            CODE_STAT_FULL : CODE_MSG_FULL;
              r_nxt.valid = 1'b1;
              r_nxt.st    = ST_REPORT;
            end else begin
              r_nxt.st = ST_MSG_RX;
            end
          end else begin
            r_nxt.code  = CODE_BAD_PHASE;
            r_nxt.valid = 1'b1;
            r_nxt.st    = ST_REPORT;
          end
        end
      end
      ST_MSG_RX: begin
        if (scsi_rst_s) begin
          r_nxt.code = CODE_SCSI_RST;
          r_nxt.step = STEP_DURING;
          r_nxt.st   = ST_EXIT;
        end else if (rx_byte_done_in) begin
          r_nxt.code  = r_r.rx_status ?
                        CODE_STAT_RX : CODE_MSG_RX;
          r_nxt.step  = STEP_DURING;
          r_nxt.valid = 1'b1;
          r_nxt.st    = ST_REPORT;
        end
      end
      ST_XFER: begin
        // Errors are latched, ATN goes up and the transfer goes on
        r_nxt.pe_dma    = r_r.pe_dma | dma_par_err_in;
        r_nxt.pe_mpu    = r_r.pe_mpu | mpu_par_err_in;
        r_nxt.pe_scsi   = r_r.pe_scsi | scsi_par_err_in;
        r_nxt.ofs_err   = r_r.ofs_err | (offset_err_in & sync_mode_in);
        r_nxt.req_short = r_r.req_short | req_short_in;
        if (dma_par_err_in || mpu_par_err_in || scsi_par_err_in ||
            (offset_err_in && sync_mode_in) || req_short_in) begin
          r_nxt.atn = 1'b1;
        end
        r_nxt.step = STEP_DURING;
        if (scsi_rst_s) begin
          r_nxt.code = CODE_SCSI_RST;
          r_nxt.st   = ST_EXIT;
        end else if (bus_free_s) begin
          r_nxt.code = CODE_BUS_FREE;
          r_nxt.st   = ST_EXIT;
        end else if (phase_chg_in) begin
          r_nxt.code = CODE_PHASE_CHG;
          r_nxt.st   = ST_EXIT;
        end else if (req_timeout_in && !sync_mode_in) begin
          r_nxt.code = CODE_TIMEOUT;
          r_nxt.st   = ST_EXIT;
        end else if (pause_in) begin
          r_nxt.code = CODE_PAUSE;
          r_nxt.st   = ST_EXIT;
        end else if (xfer_done_in) begin
          r_nxt.code  = err_code;
          r_nxt.step  = end_step;
          r_nxt.valid = 1'b1;
          r_nxt.atn   = 1'b0;
          r_nxt.pad   = 1'b0;
          r_nxt.st    = ST_REPORT;
        end else if (r_r.pad) begin
          r_nxt.pad = 1'b1;
        end
      end
      ST_EXIT: begin
        // Code waits unseen until the exit sequence has ended
        if (exit_done_in) begin
          r_nxt.valid = 1'b1;
          r_nxt.atn   = 1'b0;
          r_nxt.pad   = 1'b0;
          r_nxt.st    = ST_REPORT;
        end
      end
      ST_REPORT: begin
        if (int_read_in) begin
          if (r_r.pend22) begin
            r_nxt.code   = CODE_PE_MPU;
            r_nxt.step   = STEP_BEFORE;
            r_nxt.pend22 = reg_par_err_in;
          end else begin
            r_nxt.valid = 1'b0;
            r_nxt.st    = ST_IDLE;
          end
        end
      end
      default: begin
        r_nxt    = '0;
        r_nxt.st = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      r_r    <= '0;
      r_r.st <= ST_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs
  assign int_code_out  = r_r.code;
  assign int_step_out  = r_r.step;
  assign int_valid_out = r_r.valid;
  assign atn_out       = r_r.atn;
  assign padding_out   = r_r.pad;
  assign rx_accept_out = (r_r.st == ST_MSG_RX);
  assign exit_req_out  = (r_r.st == ST_EXIT);
  assign busy_out      = (r_r.st != ST_IDLE) && (r_r.st != ST_REPORT);

  // Checks
  a_report_hold: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    int_valid_out && !int_read_in
    |=> int_valid_out && $stable(int_code_out) && $stable(int_step_out))
    else $error("Report changed before it was read");
  a_timeout_exit: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_TIMEOUT
    |-> int_step_out == STEP_DURING && $past(exit_req_out))
    else $error("Timeout reported without exit or wrong step");
  a_free_exit: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_BUS_FREE
    |-> int_step_out == STEP_DURING && $past(exit_req_out))
    else $error("Bus free reported without exit processing");
  a_phase_exit: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_PHASE_CHG
    |-> $past(exit_req_out, 1))
    else $error("Phase change reported without exit processing");
  a_bad_phase: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    r_r.st == ST_WAIT && first_req_in && !auto_rx_mode_in
    && phase_in != PH_DATA_OUT && !scsi_rst_s
    |=> int_valid_out && int_code_out == CODE_BAD_PHASE)
    else $error("Wrong first phase not reported as 54H");
  a_rx_taken: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && (int_code_out == CODE_MSG_RX ||
    int_code_out == CODE_STAT_RX) |-> $past(rx_accept_out))
    else $error("Message or status reported without a byte taken");
  a_buf_refuse: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && (int_code_out == CODE_MSG_FULL ||
    int_code_out == CODE_STAT_FULL) |-> !$past(rx_accept_out)
    && $past(rx_buf_full_in))
    else $error("Full buffer code without a full buffer");
  a_normal_step: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_NORMAL
    |-> int_step_out == STEP_MANUAL || int_step_out == STEP_AUTO_ACK)
    else $error("Normal end with a wrong step");
  a_zero_pad: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    r_r.st == ST_IDLE && !r_r.pend22 && cmd_start_in && count_zero_in
    |=> padding_out ##0 int_code_out != CODE_ZERO_CNT)
    else $error("Zero count did not start padding");
  a_free_before: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_FREE_PRE
    |-> int_step_out == STEP_BEFORE && $past(auto_rx_mode_in))
    else $error("70H reported outside auto receive mode");
  a_err_atn: assert property (
    @(posedge core_clk_in) disable iff (!rstn_in)
    r_r.st == ST_XFER && (dma_par_err_in || scsi_par_err_in || req_short_in)
    |=> atn_out)
    else $error("ATN not raised on a transfer error");
  c_normal_end: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    $rose(int_valid_out) && int_code_out == CODE_NORMAL);
  c_exit_report: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    exit_req_out ##1 $rose(int_valid_out));
  c_pend22: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
    int_valid_out && int_read_in ##1 int_step_out == STEP_BEFORE);
endmodule // dtcc_report
`default_nettype wire

//--- dtcc_report_tb_top.sv
// Self-checking testbench for the completion code reporter
`default_nettype none
module dtcc_report_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dtcc_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, cmd = 1'b0, czero = 1'b0;
  logic        arx = 1'b0, aack = 1'b0, syn = 1'b0, full = 1'b0;
  logic        rd = 1'b0, seen = 1'b0, a, l;
  logic  [6:0] ev = 7'h00;
  logic        freq, rxd, lack, exd, valid, atn, pad, acc, exreq, busy;
  logic  [2:0] phase, tv;
  logic  [1:0] pins;
  logic  [7:0] code, step, lag = 8'h00, lf = 8'h06;
  logic [15:0] held, q[$];
  int          miscompares = 0, tests_run = 0;
  logic  [6:0] em [9] = '{7'h01, 7'h02, 7'h04, 7'h05, 7'h06, 7'h08, 7'h10,
                          7'h18, 7'h08};
  logic  [7:0] ec [9] = '{CODE_PE_DMA, CODE_PE_MPU, CODE_PE_SCSI,
    CODE_PE_DMA_SC, CODE_PE_MPU_SC, CODE_OFS_ERR, CODE_REQ_SHORT,
    CODE_OFS_SHORT, CODE_NORMAL};
  logic  [7:0] xc [5] = '{CODE_TIMEOUT, CODE_PHASE_CHG, CODE_PAUSE,
                          CODE_BUS_FREE, CODE_SCSI_RST};
  logic  [7:0] wc [7] = '{CODE_BAD_PHASE, CODE_MSG_RX, CODE_STAT_RX,
    CODE_MSG_FULL, CODE_STAT_FULL, CODE_FREE_PRE, CODE_SCSI_RST};
  logic  [2:0] wp [5] = '{PH_STATUS, PH_MSG_IN, PH_STATUS, PH_MSG_IN,
                          PH_STATUS};
  dtcc_report DUT (.core_clk_in(clk), .rstn_in(rstn),
    .scsi_rst_pin_in(pins[1]), .bus_free_pin_in(pins[0]),
    .cmd_start_in(cmd), .count_zero_in(czero), .auto_rx_mode_in(arx),
    .auto_ack_mode_in(aack), .sync_mode_in(syn), .first_req_in(freq),
    .phase_in(phase), .rx_buf_full_in(full), .rx_byte_done_in(rxd),
    .phase_chg_in(tv[0]), .req_timeout_in(tv[1]), .pause_in(ev[5]),
    .xfer_done_in(tv[2]), .last_ack_rel_in(lack), .exit_done_in(exd),
    .dma_par_err_in(ev[0]), .mpu_par_err_in(ev[1]),
    .scsi_par_err_in(ev[2]), .reg_par_err_in(ev[6]),
    .offset_err_in(ev[3]), .req_short_in(ev[4]), .int_read_in(rd),
    .int_code_out(code), .int_step_out(step), .int_valid_out(valid),
    .atn_out(atn), .padding_out(pad), .rx_accept_out(acc),
    .exit_req_out(exreq), .busy_out(busy));
  dtcc_target TGT (.core_clk_in(clk), .lag_in(lag), .rx_accept_in(acc),
    .exit_req_in(exreq), .first_req_out(freq), .phase_out(phase),
    .rx_done_out(rxd), .evt_out(tv), .last_ack_out(lack),
    .exit_done_out(exd), .pins_out(pins));
  // Clock of 100 ns
  always #50 clk = ~clk;
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp_rep(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_lvl(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic expect_rep(input logic [7:0] c, input logic [7:0] s);
    q.push_back({c, s});
  endtask
  task automatic fire(input logic [6:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
  endtask
  // Start a command; md is count zero, auto rx, auto ack, sync
  task automatic start(input logic [3:0] md);
    lf = nxt(lf);
    @(posedge clk);
    {czero, arx, aack, syn} <= md;
    lag <= {5'h00, lf[2:0]};
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
  endtask
  // Wait for a report, then read it
  task automatic take();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (valid !== 1'b1 && n < 200);
    if (n >= 200) miscompares++;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic test_done();
    if (q.size() != 0) miscompares++;
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare each new report with the oldest note, then watch it stand
  always @(posedge clk) begin
    if (valid === 1'b1 && !seen) begin
      cmp_rep(q.size() != 0 ? q.pop_front() : 16'hFFFF, {code, step});
      held = {code, step};
      seen = 1'b1;
    end else if (seen && valid === 1'b1) begin
      cmp_rep(held, {code, step});
    end
    if (rd) seen = 1'b0;
  end
  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_lvl(1'b0, valid | atn | pad | busy);
    @(posedge clk);
    rstn <= 1'b1;
    // Normal ends: manual, auto ACK, padding
    for (int k = 0; k < 3; k++) begin
      start({k == 2, 1'b0, k != 0, 1'b0});
      expect_rep(CODE_NORMAL, k == 1 ? STEP_AUTO_ACK : STEP_MANUAL);
      TGT.req(PH_DATA_OUT);
      @(negedge clk);
      cmp_lvl(k == 2, pad);
      @(posedge clk);
      TGT.evt(3'b100, 1'b1);
      take();
    end
    // Parity, offset and REQ period errors, then the end of transfer
    for (int i = 0; i < 9; i++) begin
      a = lf[3];
      l = lf[4];
      start({2'b00, a, i == 5 || i == 7});
      if (ec[i] == CODE_NORMAL) begin
        expect_rep(ec[i], a & l ? STEP_AUTO_ACK : STEP_MANUAL);
      end else begin
        expect_rep(ec[i], a & l ? STEP_LAST_ACK : STEP_DURING);
      end
      TGT.req(PH_DATA_OUT);
      fire(em[i]);
      @(negedge clk);
      cmp_lvl(ec[i] != CODE_NORMAL, atn);
      @(posedge clk);
      TGT.evt(3'b100, l);
      take();
    end
    // Ends through exit processing
    for (int j = 0; j < 5; j++) begin
      start(4'b0000);
      expect_rep(xc[j], STEP_DURING);
      TGT.req(PH_DATA_OUT);
      case (j)
        0: TGT.evt(3'b010, 1'b0);
        1: TGT.evt(3'b001, 1'b0);
        2: fire(7'h20);
        3: TGT.pin(2'b01, 4);
        default: TGT.pin(2'b10, 4);
      endcase
      take();
    end
    // First REQ phase and conditions before the transfer
    for (int j = 0; j < 7; j++) begin
      full <= j == 3 || j == 4;
      start({1'b0, j != 0 && j != 6, 2'b00});
      expect_rep(wc[j], j > 4 ? STEP_BEFORE : STEP_DURING);
      if (j < 5) begin
        TGT.req(wp[j]);
        @(negedge clk);
        cmp_lvl(j == 1 || j == 2, acc);
      end else begin
        TGT.pin(j == 5 ? 2'b01 : 2'b10, 4);
      end
      take();
    end
    full <= 1'b0;
    // Register parity queued behind a normal end, then from idle
    start(4'b0000);
    expect_rep(CODE_NORMAL, STEP_MANUAL);
    expect_rep(CODE_PE_MPU, STEP_BEFORE);
    TGT.req(PH_DATA_OUT);
    fire(7'h40);
    TGT.evt(3'b100, 1'b0);
    take();
    take();
    expect_rep(CODE_PE_MPU, STEP_BEFORE);
    @(posedge clk);
    fire(7'h40);
    take();
    test_done();
  end
endmodule // dtcc_report_tb_top
`default_nettype wire

//--- dtcc_sync.sv
// Two-flop synchroniser for the asynchronous SCSI bus condition pins
`default_nettype none
module dtcc_sync (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       rstn_in,
  // Pin side
  input  wire logic [dtcc_pkg::SYNC_W-1:0] async_in,
  // Core side
  output logic      [dtcc_pkg::SYNC_W-1:0] sync_out
);
  import dtcc_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } dtcc_sync_type;

  dtcc_sync_type r_r;
  dtcc_sync_type r_nxt;

  // First stage feeds only the second stage
  always_comb begin
    r_nxt.meta   = async_in;
    r_nxt.stable = r_r.meta;
  end

  // Register the stages
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sync_out = r_r.stable;
endmodule // dtcc_sync
`default_nettype wire

//--- dtcc_target.sv
// SCSI target model: first REQ, bus events, bus pins, engine answers
`default_nettype none
module dtcc_target (
  // Clock
  input  wire logic       core_clk_in,
  // Answer delay in cycles
  input  wire logic [7:0] lag_in,
  // Design requests that the far side answers
  input  wire logic       rx_accept_in,
  input  wire logic       exit_req_in,
  // Target side events
  output logic            first_req_out,
  output logic      [2:0] phase_out,
  output logic            rx_done_out,
  output logic      [2:0] evt_out,
  output logic            last_ack_out,
  output logic            exit_done_out,
  output logic      [1:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  // Quiet bus at time zero
  initial begin
    first_req_out = 1'b0;
    phase_out     = 3'h5;
    rx_done_out   = 1'b0;
    evt_out       = 3'h0;
    last_ack_out  = 1'b0;
    exit_done_out = 1'b0;
    pins_out      = 2'h0;
  end
  // Answer a byte take or an exit request after lag_in cycles
  always @(posedge core_clk_in) begin
    rx_done_out   <= 1'b0;
    exit_done_out <= 1'b0;
    if ((rx_accept_in || exit_req_in) && !rx_done_out && !exit_done_out) begin
      if (cnt >= lag_in) begin
        rx_done_out   <= rx_accept_in;
        exit_done_out <= exit_req_in;
        cnt           <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else begin
      cnt <= 8'h00;
    end
  end
  // One REQ in a phase; the phase lines show junk afterwards
  task automatic req(input logic [2:0] ph);
    first_req_out <= 1'b1;
    phase_out     <= ph;
    @(posedge core_clk_in);
    first_req_out <= 1'b0;
    phase_out     <= ~ph;
  endtask
  // Event pulse: bit 0 phase change, 1 timeout, 2 transfer done
  task automatic evt(input logic [2:0] m, input logic la);
    evt_out      <= m;
    last_ack_out <= la;
    @(posedge core_clk_in);
    evt_out      <= 3'h0;
    last_ack_out <= ~la;
  endtask
  // Bus pins: bit 0 bus free, bit 1 SCSI reset, held n cycles
  task automatic pin(input logic [1:0] m, input int n);
    pins_out <= m;
    repeat (n) @(posedge core_clk_in);
    pins_out <= 2'h0;
  endtask
endmodule // dtcc_target
`default_nettype wire
